/* ladder_interlock_pkg.sv */
package ladder_interlock_pkg;

    // Instruction classes presented by the scan engine, one per address
    typedef enum logic [3:0] {
        OP_NOP = 4'h0,
        OP_LOAD = 4'h1,
        OP_LOAD_NOT = 4'h2,
        OP_AND = 4'h3,
        OP_AND_NOT = 4'h4,
        OP_OR = 4'h5,
        OP_OR_NOT = 4'h6,
        OP_OUTPUT = 4'h7,
        OP_TIMER = 4'h8,
        OP_COUNTER = 4'h9,
        OP_LATCH = 4'hA,
        OP_INTERLOCK_START = 4'hB,
        OP_INTERLOCK_RELEASE = 4'hC,
        OP_STEP_DEFINE = 4'hD,
        OP_SEQUENCE_STAGE_ADVANCE = 4'hE,
        OP_END = 4'hF
    } opcode_t;

    // What the execution unit is told to do with an output-class instruction
    typedef enum logic [1:0] {
        ACT_EXECUTE = 2'h0,
        ACT_RESET = 2'h1,
        ACT_FREEZE = 2'h2,
        ACT_SKIP = 2'h3
    } action_t;

    // Fault vector layout
    localparam int FAULT_W = 4;
    localparam int FAULT_ORPHAN_RELEASE = 0;
    localparam int FAULT_UNPAIRED_START = 1;
    localparam int FAULT_STAGE_IN_SECTION = 2;
    localparam int FAULT_BAD_OPERAND = 3;

    // Reset values
    localparam logic [FAULT_W-1:0] FAULT_RESET = 4'h0;
    localparam logic INHIBIT_RESET = 1'b0;
    localparam logic OPEN_RESET = 1'b0;
    localparam logic COND_RESET = 1'b0;

    // Result latency after an instruction is presented, in clock cycles
    localparam int RESULT_LATENCY = 1;

endpackage

/* line_cond_if.sv */
`timescale 1ns/10ps
interface line_cond_if;
    logic valid;
    logic scan_start;
    ladder_interlock_pkg::opcode_t op;
    logic operand_bit;
    logic cond;
    logic pending;

    modport feeder (
        output valid,
        output scan_start,
        output op,
        output operand_bit,
        input cond,
        input pending
    );

    modport accum (
        input valid,
        input scan_start,
        input op,
        input operand_bit,
        output cond,
        output pending
    );
endinterface

/* line_condition_accumulator.sv */
`timescale 1ns/10ps
module line_condition_accumulator (
    input wire logic clock,
    input wire logic resetn,
    line_cond_if.accum lif
);

    logic cond_q, cond_d;
    logic pending_q, pending_d;
    logic is_output;

    // Output-class and interlock instructions consume the line's condition
    always_comb begin
        is_output = lif.op inside {ladder_interlock_pkg::OP_OUTPUT,
            ladder_interlock_pkg::OP_TIMER, ladder_interlock_pkg::OP_COUNTER,
            ladder_interlock_pkg::OP_LATCH, ladder_interlock_pkg::OP_INTERLOCK_START,
            ladder_interlock_pkg::OP_INTERLOCK_RELEASE};
        cond_d = cond_q;
        pending_d = lif.scan_start ? 1'b0 : pending_q;
        if (lif.valid) begin
            // The line is folded up to its right-hand instruction before a branch reloads
            case (lif.op)
                ladder_interlock_pkg::OP_LOAD: begin
                    cond_d = lif.operand_bit;
                    pending_d = 1'b1;
                end
                ladder_interlock_pkg::OP_LOAD_NOT: begin
                    cond_d = ~lif.operand_bit;
                    pending_d = 1'b1;
                end
                ladder_interlock_pkg::OP_AND: begin
                    cond_d = cond_q & lif.operand_bit;
                    pending_d = 1'b1;
                end
                ladder_interlock_pkg::OP_AND_NOT: begin
                    cond_d = cond_q & ~lif.operand_bit;
                    pending_d = 1'b1;
                end
                ladder_interlock_pkg::OP_OR: begin
                    cond_d = cond_q | lif.operand_bit;
                    pending_d = 1'b1;
                end
                ladder_interlock_pkg::OP_OR_NOT: begin
                    cond_d = cond_q | ~lif.operand_bit;
                    pending_d = 1'b1;
                end
                default: begin
                    if (is_output) begin
                        pending_d = 1'b0;
                    end
                end
            endcase
        end
    end

    // Registers only
    always_ff @(posedge clock) begin
        if (!resetn) begin
            cond_q <= ladder_interlock_pkg::COND_RESET;
            pending_q <= 1'b0;
        end else begin
            cond_q <= cond_d;
            pending_q <= pending_d;
        end
    end

    assign lif.cond = cond_q;
    assign lif.pending = pending_q;

    // A freshly loaded line carries the loaded bit into its output instruction
    sequence s_load_line;
        lif.valid && lif.op == ladder_interlock_pkg::OP_LOAD;
    endsequence
    property p_line_load;
        @(posedge clock) disable iff (!resetn)
        s_load_line |=> (cond_q == $past(lif.operand_bit)) && pending_q;
    endproperty
    a_line_load: assert property (p_line_load)
        else $error("loaded condition not held for the line");

endmodule

/* ladder_interlock_control.sv */
`timescale 1ns/10ps
module ladder_interlock_control (
    input wire logic clock,
    input wire logic resetn,
    input wire logic scan_start,
    input wire logic instr_valid,
    input wire ladder_interlock_pkg::opcode_t instr_op,
    input wire logic operand_bit,
    input wire logic operand_present,
    output logic result_valid_q,
    output ladder_interlock_pkg::action_t result_action_q,
    output logic result_cond_q,
    output logic inhibit_q,
    output logic section_open_q,
    output logic [ladder_interlock_pkg::FAULT_W-1:0] fault_q
);

    line_cond_if lif ();

    // Line condition is kept in the accumulator; it feeds every output instruction
    assign lif.valid = instr_valid;
    assign lif.scan_start = scan_start;
    assign lif.op = instr_op;
    assign lif.operand_bit = operand_bit;

    line_condition_accumulator u_accum (
        .clock(clock),
        .resetn(resetn),
        .lif(lif)
    );

    logic inhibit_d, section_open_d;
    logic result_valid_d, result_cond_d;
    ladder_interlock_pkg::action_t result_action_d;
    logic [ladder_interlock_pkg::FAULT_W-1:0] fault_d, fault_new;
    logic inhibit_base, open_base;
    logic is_lock_op;

    // Start of scan wipes the interlock state before this cycle's instruction
    assign inhibit_base = scan_start ? 1'b0 : inhibit_q;
    assign open_base = scan_start ? 1'b0 : section_open_q;
    assign is_lock_op = (instr_op == ladder_interlock_pkg::OP_INTERLOCK_START) ||
                      (instr_op == ladder_interlock_pkg::OP_INTERLOCK_RELEASE);

    // Interlock flag and section tracking
    always_comb begin
        inhibit_d = inhibit_base;
        section_open_d = open_base;
        if (instr_valid) begin
            case (instr_op)
                ladder_interlock_pkg::OP_INTERLOCK_START: begin
                    // An OFF start suppresses from here on; an ON inner start cannot
                    // lift an outer OFF, so one sticky flag covers nesting
                    inhibit_d = inhibit_base | ~lif.cond;
                    section_open_d = 1'b1;
                end
                ladder_interlock_pkg::OP_INTERLOCK_RELEASE: begin
                    // Normal execution resumes with the next line
                    inhibit_d = 1'b0;
                    section_open_d = 1'b0;
                end
                default: begin
                    inhibit_d = inhibit_base;
                end
            endcase
        end
    end

    // Action chosen for output-class instructions
    always_comb begin
        result_valid_d = 1'b0;
        result_action_d = ladder_interlock_pkg::ACT_EXECUTE;
        result_cond_d = 1'b0;
        if (instr_valid) begin
            case (instr_op)
                ladder_interlock_pkg::OP_OUTPUT: begin
                    result_valid_d = 1'b1;
                    // Suppressed outputs are simply not executed
                    result_action_d = inhibit_base ? ladder_interlock_pkg::ACT_SKIP
                                                   : ladder_interlock_pkg::ACT_EXECUTE;
                    result_cond_d = lif.cond & ~inhibit_base;
                end
                ladder_interlock_pkg::OP_TIMER: begin
                    result_valid_d = 1'b1;
                    result_action_d = inhibit_base ? ladder_interlock_pkg::ACT_RESET
                                                   : ladder_interlock_pkg::ACT_EXECUTE;
                    result_cond_d = lif.cond & ~inhibit_base;
                end
                ladder_interlock_pkg::OP_COUNTER,
                ladder_interlock_pkg::OP_LATCH: begin
                    result_valid_d = 1'b1;
                    // Frozen, not cleared: a latch bit keeps its state
                    result_action_d = inhibit_base ? ladder_interlock_pkg::ACT_FREEZE
                                                   : ladder_interlock_pkg::ACT_EXECUTE;
                    result_cond_d = lif.cond & ~inhibit_base;
                end
                default: begin
                    result_valid_d = 1'b0;
                end
            endcase
        end
    end

    // Program faults; a new fault wins over the clear at scan start
    always_comb begin
        fault_new = '0;
        if (instr_valid) begin
            // A release without an open section has no meaning
            if (instr_op == ladder_interlock_pkg::OP_INTERLOCK_RELEASE && !open_base) begin
                fault_new[ladder_interlock_pkg::FAULT_ORPHAN_RELEASE] = 1'b1;
            end
            // Section left open at end of program
            if (instr_op == ladder_interlock_pkg::OP_END && open_base) begin
                fault_new[ladder_interlock_pkg::FAULT_UNPAIRED_START] = 1'b1;
            end
            if ((instr_op == ladder_interlock_pkg::OP_STEP_DEFINE ||
                 instr_op == ladder_interlock_pkg::OP_SEQUENCE_STAGE_ADVANCE) && open_base) begin
                fault_new[ladder_interlock_pkg::FAULT_STAGE_IN_SECTION] = 1'b1;
            end
            // Interlock instructions take no operand; release line has no conditions.
            // Pending loads left from the previous scan do not count against a new scan.
            if ((is_lock_op && operand_present) ||
                (instr_op == ladder_interlock_pkg::OP_INTERLOCK_RELEASE && lif.pending &&
                 !scan_start)) begin
                fault_new[ladder_interlock_pkg::FAULT_BAD_OPERAND] = 1'b1;
            end
        end
        fault_d = (scan_start ? ladder_interlock_pkg::FAULT_RESET : fault_q) | fault_new;
    end

    // Registers only
    always_ff @(posedge clock) begin
        if (!resetn) begin
            inhibit_q <= ladder_interlock_pkg::INHIBIT_RESET;
            section_open_q <= ladder_interlock_pkg::OPEN_RESET;
            result_valid_q <= 1'b0;
            result_action_q <= ladder_interlock_pkg::ACT_EXECUTE;
            result_cond_q <= ladder_interlock_pkg::COND_RESET;
            fault_q <= ladder_interlock_pkg::FAULT_RESET;
        end else begin
            inhibit_q <= inhibit_d;
            section_open_q <= section_open_d;
            result_valid_q <= result_valid_d;
            result_action_q <= result_action_d;
            result_cond_q <= result_cond_d;
            fault_q <= fault_d;
        end
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!resetn);

    // Helper: instruction seen while the section is suppressed
    logic sup_now;
    assign sup_now = instr_valid && inhibit_base;

    sequence s_timer_sup;
        sup_now && instr_op == ladder_interlock_pkg::OP_TIMER;
    endsequence
    sequence s_hold_sup;
        sup_now && (instr_op == ladder_interlock_pkg::OP_COUNTER ||
                    instr_op == ladder_interlock_pkg::OP_LATCH);
    endsequence

    property p_timer_reset;
        s_timer_sup |=> result_valid_q && result_action_q == ladder_interlock_pkg::ACT_RESET
                        && !result_cond_q;
    endproperty
    a_timer_reset: assert property (p_timer_reset)
        else $error("suppressed timer not reset");

    property p_hold_freeze;
        s_hold_sup |=> result_valid_q && result_action_q == ladder_interlock_pkg::ACT_FREEZE;
    endproperty
    a_hold_freeze: assert property (p_hold_freeze)
        else $error("suppressed counter or latch not frozen");

    property p_output_skip;
        sup_now && instr_op == ladder_interlock_pkg::OP_OUTPUT |=>
            result_action_q == ladder_interlock_pkg::ACT_SKIP && !result_cond_q;
    endproperty
    a_output_skip: assert property (p_output_skip)
        else $error("suppressed output was executed");

    property p_and_equiv;
        instr_valid && !inhibit_base && instr_op == ladder_interlock_pkg::OP_OUTPUT |=>
            result_cond_q == $past(lif.cond) && result_action_q == ladder_interlock_pkg::ACT_EXECUTE;
    endproperty
    a_and_equiv: assert property (p_and_equiv)
        else $error("enabled line result differs from its condition");

    property p_start_off;
        instr_valid && instr_op == ladder_interlock_pkg::OP_INTERLOCK_START && !lif.cond
            |=> inhibit_q && section_open_q;
    endproperty
    a_start_off: assert property (p_start_off)
        else $error("OFF interlock start did not suppress");

    property p_nested_hold;
        instr_valid && instr_op == ladder_interlock_pkg::OP_INTERLOCK_START && inhibit_base
            |=> inhibit_q;
    endproperty
    a_nested_hold: assert property (p_nested_hold)
        else $error("inner start lifted outer suppression");

    property p_release_clear;
        instr_valid && instr_op == ladder_interlock_pkg::OP_INTERLOCK_RELEASE
            |=> !inhibit_q && !section_open_q;
    endproperty
    a_release_clear: assert property (p_release_clear)
        else $error("release did not clear interlock");

    property p_suppress_holds;
        inhibit_q && !scan_start && !(instr_valid &&
            instr_op == ladder_interlock_pkg::OP_INTERLOCK_RELEASE) |=> inhibit_q;
    endproperty
    a_suppress_holds: assert property (p_suppress_holds)
        else $error("suppression ended before release");

    property p_stage_fault;
        instr_valid && open_base && instr_op == ladder_interlock_pkg::OP_SEQUENCE_STAGE_ADVANCE
            |=> fault_q[ladder_interlock_pkg::FAULT_STAGE_IN_SECTION];
    endproperty
    a_stage_fault: assert property (p_stage_fault)
        else $error("stage instruction in section not flagged");

    property p_release_line_fault;
        instr_valid && instr_op == ladder_interlock_pkg::OP_INTERLOCK_RELEASE && lif.pending
            && !scan_start |=> fault_q[ladder_interlock_pkg::FAULT_BAD_OPERAND];
    endproperty
    a_release_line_fault: assert property (p_release_line_fault)
        else $error("conditioned release not flagged");

endmodule

/* ladder_program_memory.sv */
`timescale 1ns/10ps
module ladder_program_memory (
    input wire logic clock,
    input wire logic resetn,
    input wire logic wr_en,
    input wire logic [3:0] wr_addr,
    input wire ladder_interlock_pkg::opcode_t wr_op,
    input wire logic wr_bit,
    input wire logic wr_present,
    input wire logic run,
    output logic scan_start,
    output logic instr_valid,
    output ladder_interlock_pkg::opcode_t instr_op,
    output logic operand_bit,
    output logic operand_present,
    output logic busy
);
    ladder_interlock_pkg::opcode_t op_mem [16];
    logic bit_mem [16];
    logic pres_mem [16];
    logic [3:0] pc_q;

    // Program store, written word by word before a scan
    always_ff @(posedge clock) begin
        if (wr_en) begin
            op_mem[wr_addr] <= wr_op;
            bit_mem[wr_addr] <= wr_bit;
            pres_mem[wr_addr] <= wr_present;
        end
    end

    // One instruction per address, in address order, up to END
    always_ff @(posedge clock) begin
        if (!resetn) begin
            busy <= 1'b0;
            pc_q <= 4'h0;
            scan_start <= 1'b0;
            instr_valid <= 1'b0;
            instr_op <= ladder_interlock_pkg::OP_NOP;
            operand_bit <= 1'b0;
            operand_present <= 1'b0;
        end else if (run && !busy) begin
            busy <= 1'b1;
            pc_q <= 4'h0;
        end else if (busy) begin
            scan_start <= (pc_q == 4'h0);
            instr_valid <= 1'b1;
            instr_op <= op_mem[pc_q];
            operand_bit <= bit_mem[pc_q];
            operand_present <= pres_mem[pc_q];
            pc_q <= pc_q + 4'h1;
            if (op_mem[pc_q] == ladder_interlock_pkg::OP_END) begin
                busy <= 1'b0;
            end
        end else begin
            // Idle bit toggles so a stale operand is never mistaken for data
            scan_start <= 1'b0;
            instr_valid <= 1'b0;
            instr_op <= ladder_interlock_pkg::OP_NOP;
            operand_bit <= ~operand_bit;
            operand_present <= 1'b0;
        end
    end
endmodule

/* testbench.sv */
`timescale 1ns/10ps
module testbench;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic wr_en = 1'b0;
    logic [3:0] wr_addr = 4'h0;
    ladder_interlock_pkg::opcode_t wr_op = ladder_interlock_pkg::OP_NOP;
    logic wr_bit = 1'b0;
    logic wr_present = 1'b0;
    logic run = 1'b0;
    logic scan_start, instr_valid, operand_bit, operand_present, busy;
    ladder_interlock_pkg::opcode_t instr_op;
    logic result_valid_q, result_cond_q, inhibit_q, section_open_q;
    ladder_interlock_pkg::action_t result_action_q;
    logic [ladder_interlock_pkg::FAULT_W-1:0] fault_q;
    logic [2:0] res_q [$];
    int err_count = 0;
    int n_checks = 0;

    always #10 clock = ~clock;

    ladder_program_memory i_prog (.clock(clock), .resetn(resetn), .wr_en(wr_en),
        .wr_addr(wr_addr), .wr_op(wr_op), .wr_bit(wr_bit), .wr_present(wr_present),
        .run(run), .scan_start(scan_start), .instr_valid(instr_valid),
        .instr_op(instr_op), .operand_bit(operand_bit),
        .operand_present(operand_present), .busy(busy));

    ladder_interlock_control i_dut (.clock(clock), .resetn(resetn),
        .scan_start(scan_start), .instr_valid(instr_valid), .instr_op(instr_op),
        .operand_bit(operand_bit), .operand_present(operand_present),
        .result_valid_q(result_valid_q), .result_action_q(result_action_q),
        .result_cond_q(result_cond_q), .inhibit_q(inhibit_q),
        .section_open_q(section_open_q), .fault_q(fault_q));

    // Result pulses last one cycle, so each is logged at the edge that ends it
    always @(posedge clock) begin
        if (result_valid_q === 1'b1) begin
            res_q.push_back({result_action_q, result_cond_q});
        end
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic finish_test;
        $display("Mismatches %0d, comparisons %0d", err_count, n_checks);
        if (err_count == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Loads a program (address 0 in the top nibble), runs one scan, judges results
    task automatic run_prog(input logic [63:0] ops, input logic [15:0] bits,
        input logic [15:0] pres, input logic [15:0] e_act, input logic [7:0] e_cond,
        input int n_res, input logic [3:0] e_fault);
        int i;
        int t;
        for (i = 0; i < 16; i++) begin
            @(posedge clock);
            wr_en <= 1'b1;
            wr_addr <= 4'(i);
            wr_op <= ladder_interlock_pkg::opcode_t'(ops[63-4*i -: 4]);
            wr_bit <= bits[15-i];
            wr_present <= pres[15-i];
        end
        @(posedge clock);
        wr_en <= 1'b0;
        run <= 1'b1;
        res_q.delete();
        @(posedge clock);
        run <= 1'b0;
        t = 0;
        do begin
            @(posedge clock);
            t++;
        end while (busy === 1'b1 && t < 40);
        if (t >= 40) begin
            err_count++;
        end
        repeat (3) @(posedge clock);
        check(8'(res_q.size()), 8'(n_res));
        for (i = 0; i < n_res && i < res_q.size(); i++) begin
            check({5'h0, res_q[i]}, {5'h0, e_act[15-2*i -: 2], e_cond[7-i]});
        end
        check({4'h0, fault_q}, {4'h0, e_fault});
    endtask

    // Interlock ON: each line follows its own conditions
    task automatic scen_on;
        run_prog(64'h1B18_1714_9CF0_0000, 16'hA200, 16'h0000,
            16'h0000, 8'hA0, 3, 4'h0);
        check({7'h0, inhibit_q}, 8'h00);
        // Every condition form except OP_AND_NOT inside an ON section, with a NOP before END
        run_prog(64'h1B23_7267_1537_C0F0, 16'h9440, 16'h0000,
            16'h0000, 8'hC0, 3, 4'h0);
    endtask

    // Interlock OFF: timer reset, counter and latch frozen, output skipped
    task automatic scen_off;
        run_prog(64'h1B18_191A_17C1_7F00, 16'h2A90, 16'h0000,
            16'h6B00, 8'h08, 5, 4'h0);
        check({7'h0, inhibit_q}, 8'h00);
        check({7'h0, section_open_q}, 8'h00);
    endtask

    // Inner OFF start suppresses from its own position to the release
    task automatic scen_nested;
        run_prog(64'h1B17_1B17_18C1_AF00, 16'hA290, 16'h0000,
            16'h3400, 8'h90, 4, 4'h0);
    endtask

    // Illegal placements raise the matching fault; a clean scan after the unpaired start clears that one
    task automatic scen_faults;
        run_prog(64'hCF00_0000_0000_0000, 16'h0000, 16'h0000, 16'h0, 8'h0, 0, 4'h1);
        run_prog(64'h1BCC_17F0_0000_0000, 16'h0800, 16'h0000,
            16'h0000, 8'h80, 1, 4'h1);
        run_prog(64'h1BF0_0000_0000_0000, 16'h0000, 16'h0000, 16'h0, 8'h0, 0, 4'h2);
        check({7'h0, inhibit_q}, 8'h01);
        check({7'h0, section_open_q}, 8'h01);
        run_prog(64'h17F0_0000_0000_0000, 16'h8000, 16'h0000,
            16'h0000, 8'h80, 1, 4'h0);
        run_prog(64'h1BDC_F000_0000_0000, 16'h8000, 16'h0000, 16'h0, 8'h0, 0, 4'h4);
        run_prog(64'h1BEC_F000_0000_0000, 16'h8000, 16'h0000, 16'h0, 8'h0, 0, 4'h4);
        run_prog(64'h1BCF_0000_0000_0000, 16'h8000, 16'h4000, 16'h0, 8'h0, 0, 4'h8);
        run_prog(64'h1BCF_0000_0000_0000, 16'h8000, 16'h2000, 16'h0, 8'h0, 0, 4'h8);
        run_prog(64'h1B1C_F000_0000_0000, 16'hA000, 16'h0000, 16'h0, 8'h0, 0, 4'h8);
    endtask

    // Main sequence
    initial begin
        repeat (5) @(posedge clock);
        resetn <= 1'b1;
        @(posedge clock);
        scen_on();
        scen_off();
        scen_nested();
        scen_faults();
        finish_test();
    end

    // Watchdog: the whole run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clock);
        err_count++;
        finish_test();
    end
endmodule
